// ===== bench/flash_dev_model.sv
// Behavioural flash device: command decoder, sticky status, busy timer, completion pin.
// Assumes commands latch on the rising write strobe; i_clk only times the busy period.
`timescale 1ns/10ps
`default_nettype none
module flash_dev_model (
	input wire logic i_clk,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [20:0] i_addr,
	input wire logic [15:0] i_dq,
	input wire logic i_vpp_low,
	input wire logic i_protect,
	input wire logic i_seq_bad,
	input wire logic [1:0] i_susp,
	input wire logic [15:0] i_busy_cyc,
	output logic [15:0] o_dq,
	output logic o_pin
);
	logic [15:0] arr [0:255]; // Small array window, address bits 7:0
	logic [7:0] sr = 8'h00; // Error bits, sticky until clear
	logic [7:0] pend = 8'h00; // Setup code awaiting its second cycle
	logic [20:0] pa = 21'h0; // Address given with the setup code
	logic rd_stat = 1'b0; // Reads return status rather than array
	logic [15:0] h0 = 16'h0; // Latest word written
	logic [15:0] h1 = 16'h0; // Word written before it
	logic [15:0] last = 16'h0; // Last value driven, inverted when released
	logic ers; // Pending operation is an erase
	logic [7:0] stat;
	logic [15:0] val;
	int busy = 0;
	// Bit 0 reads 1 so the host must mask it; low bits are noise while busy
	assign stat = (busy != 0) ? {1'b0, 7'h55 ^ busy[6:0]} :
		{1'b1, sr[6] | i_susp[1], sr[5:3], sr[2] | i_susp[0], sr[1], 1'b1};
	assign val = rd_stat ? {8'h00, stat} : arr[i_addr[7:0]];
	assign o_dq = (!i_ce_n && !i_oe_n) ? val : ~last;
	assign o_pin = (busy == 0);
	always @(posedge i_oe_n) last = val;
	always @(posedge i_clk) if (busy != 0) busy = busy - 1;
	// Command decoder
	always @(posedge i_we_n) if (!i_ce_n) begin
		h1 = h0;
		h0 = i_dq;
		if (pend != 8'h00) begin
			ers = (pend == 8'h20) || (pend == 8'h30);
			if (i_seq_bad || (ers && i_dq[7:0] != 8'hd0) || (pend != 8'h30 && i_addr != pa)) begin
				sr[5:4] = 2'b11;
			end else if (i_vpp_low) begin
				sr[3] = 1'b1;
				sr[ers ? 5 : 4] = 1'b1;
			end else if (i_protect) begin
				sr[1] = 1'b1;
				sr[ers ? 5 : 4] = 1'b1;
			end else if (ers) begin
				for (int i = 0; i < 256; i++) if (pend == 8'h30 || i[7:4] == pa[7:4]) arr[i] = 16'hffff;
			end else arr[pa[7:0]] = i_dq;
			busy = i_busy_cyc;
			pend = 8'h00;
		end else case (i_dq[7:0])
			8'h20, 8'h30, 8'h40, 8'h10: begin
				pend = i_dq[7:0];
				pa = i_addr;
				rd_stat = 1'b1;
			end
			8'h70: rd_stat = 1'b1;
			8'h50: sr = 8'h00;
			8'hff: rd_stat = 1'b0;
			default: sr[5:4] = 2'b11;
		endcase
	end
endmodule
`default_nettype wire

// ===== bench/flash_host_ctrl_assertions.sv
// Port-level checks of the flash host controller.
// Assumes one clock domain; bound to every flash_host_ctrl instance.
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl_chk (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_flash_ce_n,
	input wire logic o_flash_we_n,
	input wire logic o_flash_oe_n,
	input wire logic [20:0] o_flash_addr,
	input wire logic [15:0] o_flash_dq,
	input wire logic o_flash_dq_oe_n
);
	default clocking dc @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);
	// Write strobe: four low cycles, then released
	sequence we_pulse;
		!o_flash_we_n [*4] ##1 o_flash_we_n;
	endsequence
	// Read strobe has the same shape
	sequence oe_pulse;
		!o_flash_oe_n [*4] ##1 o_flash_oe_n;
	endsequence
	sequence apb_setup;
		i_psel && !i_penable;
	endsequence
	AST_WE_WIDTH: assert property ($fell(o_flash_we_n) |-> we_pulse)
		else $error("write strobe width wrong");
	AST_OE_WIDTH: assert property ($fell(o_flash_oe_n) |-> oe_pulse)
		else $error("read strobe width wrong");
	AST_CE_LEAD: assert property ($fell(o_flash_we_n) |-> !$past(o_flash_ce_n))
		else $error("chip select not ahead of write strobe");
	AST_CE_TRAIL: assert property ($rose(o_flash_we_n) |-> !o_flash_ce_n ##1 o_flash_ce_n)
		else $error("chip select not held after write strobe");
	AST_DRIVE_ON_WRITE: assert property (!o_flash_we_n |-> !o_flash_dq_oe_n)
		else $error("data not driven during write strobe");
	// Flash and controller must never drive the data lines together
	AST_NO_CONTENTION: assert property (!o_flash_oe_n |-> o_flash_dq_oe_n && o_flash_we_n)
		else $error("data driven during read strobe");
	AST_CYCLE_STABLE: assert property (!o_flash_we_n && !$fell(o_flash_we_n)
		|-> $stable(o_flash_addr) && $stable(o_flash_dq))
		else $error("address or data moved in write strobe");
	AST_PREADY_ONCE: assert property (apb_setup |=> o_pready ##1 !o_pready)
		else $error("ready not one cycle after setup");
	AST_PRDATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h00000000)
		else $error("read data not zero outside access");
	AST_RAW_MASKED: assert property (o_pready && !i_pwrite && i_paddr == flash_host_pkg::REG_STATUS
		|-> o_prdata[16] == 1'b0 && o_prdata[31:24] == 8'h00)
		else $error("reserved status bit not masked");
endmodule
bind flash_host_ctrl flash_host_ctrl_chk u_chk (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.o_prdata(o_prdata), .o_pready(o_pready), .o_flash_ce_n(o_flash_ce_n),
	.o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n), .o_flash_addr(o_flash_addr),
	.o_flash_dq(o_flash_dq), .o_flash_dq_oe_n(o_flash_dq_oe_n));
`default_nettype wire

// ===== bench/flash_host_ctrl_tb_top.sv
// Self-checking bench: APB tasks drive the controller against the flash model.
// Assumes the controller answers every APB access and polls status forever.
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl_tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, ce_n, we_n, oe_n, dq_oe_n, pin;
	logic [20:0] faddr;
	logic [15:0] dq_ctl, dq_dev;
	wire [15:0] dq_bus = !dq_oe_n ? dq_ctl : dq_dev; // Level on the shared lines
	logic vpp = 1'b0, prot = 1'b0, seqb = 1'b0; // Fault injection into the model
	logic [1:0] susp = 2'b00;
	logic [15:0] bcyc = 16'd20; // Device busy time in cycles
	logic [31:0] rd; // Last read data
	logic err; // Last slave error
	int n_fail = 0, tests_run = 0, cyc = 0;
	initial forever #50 clk = ~clk;
	flash_host_ctrl uut (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_flash_ce_n(ce_n), .o_flash_we_n(we_n),
		.o_flash_oe_n(oe_n), .o_flash_addr(faddr), .i_flash_dq(dq_bus), .o_flash_dq(dq_ctl),
		.o_flash_dq_oe_n(dq_oe_n), .i_completion_pin(pin));
	flash_dev_model dev (.i_clk(clk), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
		.i_addr(faddr), .i_dq(dq_bus), .i_vpp_low(vpp), .i_protect(prot), .i_seq_bad(seqb),
		.i_susp(susp), .i_busy_cyc(bcyc), .o_dq(dq_dev), .o_pin(pin));
	task give_verdict;
		$display("Checks %0d, errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Hang guard: well above the several hundred cycles the flows take
	always @(posedge clk) begin
		cyc++;
		if (cyc == 50000) begin
			n_fail++;
			give_verdict;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One APB transfer, held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Start an operation and poll until busy drops; rd ends as the status word
	task automatic run_op(input logic [31:0] c, input logic [31:0] a, input logic [31:0] d);
		apb(1'b1, flash_host_pkg::REG_ADDR, a);
		apb(1'b1, flash_host_pkg::REG_WDATA, d);
		apb(1'b1, flash_host_pkg::REG_CTRL, c);
		do begin
			apb(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
		end while (rd[0] !== 1'b0);
	endtask
	task t_reset;
		apb(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h014, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
	endtask
	task t_erase;
		run_op(32'h1, 32'h12, 32'h0);
		chk(rd, 32'h0080_0002);
		chk({dev.h1, dev.h0}, 32'h0020_00d0);
		chk({16'h0, dev.arr[8'h1f]}, 32'h0000_ffff);
	endtask
	// Supply fault, then a protect fault without clearing: errors accumulate
	task t_sticky;
		vpp <= 1'b1;
		run_op(32'h2, 32'h0, 32'h0);
		chk(rd, 32'h00a8_0026);
		chk({dev.h1, dev.h0}, 32'h0030_00d0);
		vpp <= 1'b0;
		prot <= 1'b1;
		run_op(32'h0b, 32'h40, 32'h1234);
		chk(rd, 32'h00ba_0016);
		chk({dev.h1, dev.h0}, 32'h0010_1234);
		prot <= 1'b0;
		run_op(32'h5, 32'h0, 32'h0);
		run_op(32'h4, 32'h0, 32'h0);
		chk(rd & 32'hffff_fffc, 32'h0080_0200);
		chk({16'h0, dev.h0}, 32'h0000_0070);
	endtask
	task t_seq;
		seqb <= 1'b1;
		run_op(32'h1, 32'h12, 32'h0);
		chk(rd, 32'h00b0_0212);
		seqb <= 1'b0;
		run_op(32'h5, 32'h0, 32'h0);
	endtask
	// Slow device, pin wait, suspend flags reported
	task t_slow;
		bcyc <= 16'd300;
		susp <= 2'b11;
		run_op(32'h13, 32'h55, 32'hbeef);
		chk(rd, 32'h00c4_0382);
		chk({dev.h1, dev.h0}, 32'h0040_beef);
		chk({16'h0, dev.arr[8'h55]}, 32'h0000_beef);
		susp <= 2'b00;
		bcyc <= 16'd20;
	endtask
	task t_read;
		run_op(32'h6, 32'h55, 32'h0);
		apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
		chk(rd, 32'h0000_beef);
		chk({16'h0, dev.h0}, 32'h0000_00ff);
		run_op(32'h7, 32'h1f, 32'h0);
		apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
		chk(rd, 32'h0000_ffff);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset;
		t_erase;
		t_sticky;
		t_seq;
		t_slow;
		t_read;
		give_verdict;
	end
endmodule
`default_nettype wire

// ===== inc/flash_host_pkg.sv
// Constants shared by the flash host controller and its helpers.
// Assumes a 10 MHz system clock and a 16-bit parallel flash with a completion pin.
// How it works
// - Host masks reserved status bit 0
// - Host masks extended bits 6 to 0
// - Status bits valid only when ready
// - Host reads lock codes for lock state; not done here, protect_err only reports aborts
// - Host waits on pin or ready bit
// - Block erase is 20H then D0H
// - Chip erase is 30H then D0H
// - Write is 40H/10H then data
// - Host clears status after any error; not done here, software must order OP_CLEAR_STATUS
// - Check supply, protect, then sequence error; seq_err here ignores supply_err and protect_err
// - Host writes FFH to return array mode
package flash_host_pkg;
	// Clock and flash bus timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_SETUP_NS = 100;
	localparam int T_STROBE_NS = 400;
	localparam int T_HOLD_NS = 100;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Flash pin widths
	localparam int ADDR_W = 21;
	localparam int DQ_W = 16;
	// Flash command codes
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
	localparam logic [7:0] CMD_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_WRITE = 8'h40;
	localparam logic [7:0] CMD_WRITE_ALT = 8'h10;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	// Operation status bit positions
	localparam int OS_READY = 7;
	localparam int OS_ERASE_SUSP = 6;
	localparam int OS_ERASE_ERR = 5;
	localparam int OS_WRITE_ERR = 4;
	localparam int OS_SUPPLY = 3;
	localparam int OS_WRITE_SUSP = 2;
	localparam int OS_PROTECT = 1;
	localparam int XOS_MULTI_OK = 7;
	// Register map for software
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_ADDR = 12'h004;
	localparam logic [11:0] REG_WDATA = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00c;
	localparam logic [11:0] REG_RDATA = 12'h010;
	// Control register fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_ALT_WRITE = 3;
	localparam int CTRL_USE_PIN = 4;
	// Status register fields
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_SUPPLY_ERR = 2;
	localparam int ST_PROTECT_ERR = 3;
	localparam int ST_SEQ_ERR = 4;
	localparam int ST_ERASE_ERR = 5;
	localparam int ST_WRITE_ERR = 6;
	localparam int ST_ERASE_SUSP = 7;
	localparam int ST_WRITE_SUSP = 8;
	localparam int ST_MULTI_OK = 9;
	localparam int ST_RAW_LSB = 16;
	// Reset values
	localparam logic [7:0] OS_RESET = 8'h00;
	localparam logic [20:0] ADDR_RESET = 21'h000000;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	// Operations software may order
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_BLOCK_ERASE = 3'b001,
		OP_CHIP_ERASE = 3'b010,
		OP_WRITE = 3'b011,
		OP_READ_STATUS = 3'b100,
		OP_CLEAR_STATUS = 3'b101,
		OP_READ_ARRAY = 3'b110,
		OP_READ_WORD = 3'b111
	} op_t;
endpackage

// ===== rtl/flash_bus_cycle.sv
// One write or read cycle on the flash parallel pins.
// Assumes i_start is a one-cycle pulse given only while o_idle is high.
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic i_start,
	input wire logic i_rd,
	input wire logic [20:0] i_addr,
	input wire logic [15:0] i_data,
	input wire logic [15:0] i_dq_sync,
	output logic o_idle,
	output logic o_done,
	output logic [15:0] o_rdata,
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [20:0] o_addr,
	output logic [15:0] o_dq,
	output logic o_dq_oe_n
);
	typedef enum logic [1:0] {
		BC_IDLE = 2'b00,
		BC_SETUP = 2'b01,
		BC_STROBE = 2'b10,
		BC_HOLD = 2'b11
	} bc_state_t;

	bc_state_t state; // Cycle phase
	logic [3:0] cnt; // Cycles left in the phase after the current one
	logic rd; // Current cycle is a read
	wire cnt_end = (cnt == 4'h0);

	// Phase sequencer; address and data stay put from setup through hold
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= BC_IDLE;
			cnt <= 4'h0;
			rd <= 1'b0;
			o_idle <= 1'b1;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
			o_ce_n <= 1'b1;
			o_we_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_addr <= 21'h000000;
			o_dq <= 16'h0000;
			o_dq_oe_n <= 1'b1;
		end else begin
			o_done <= 1'b0;
			case (state)
				BC_IDLE: begin
					if (i_start) begin
						rd <= i_rd;
						o_idle <= 1'b0;
						o_addr <= i_addr;
						o_dq <= i_data;
						o_ce_n <= 1'b0;
						// Drive data only on writes to avoid contention
						o_dq_oe_n <= i_rd;
						cnt <= 4'(flash_host_pkg::SETUP_CYC - 1);
						state <= BC_SETUP;
					end
				end
				BC_SETUP: begin
					if (cnt_end) begin
						o_we_n <= rd;
						o_oe_n <= !rd;
						cnt <= 4'(flash_host_pkg::STROBE_CYC - 1);
						state <= BC_STROBE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				BC_STROBE: begin
					// Strobe covers the synchroniser delay, so data is settled here
					if (cnt_end) begin
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
						if (rd) begin
							o_rdata <= i_dq_sync;
						end
						cnt <= 4'(flash_host_pkg::HOLD_CYC - 1);
						state <= BC_HOLD;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				BC_HOLD: begin
					if (cnt_end) begin
						o_ce_n <= 1'b1;
						o_dq_oe_n <= 1'b1;
						o_idle <= 1'b1;
						o_done <= 1'b1;
						state <= BC_IDLE;
					end else begin
						cnt <= cnt - 4'h1;
					end
				end
				default: begin
					state <= BC_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== rtl/flash_host_ctrl.sv
// Host controller that runs erase, write and status flows on a parallel flash.
// Assumes an APB master on the system clock and a pulled-up open-drain completion pin.
// Software sees one operation at a time; starts while busy are ignored.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module flash_host_ctrl (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Flash pins
	output logic o_flash_ce_n,
	output logic o_flash_we_n,
	output logic o_flash_oe_n,
	output logic [20:0] o_flash_addr,
	input wire logic [15:0] i_flash_dq,
	output logic [15:0] o_flash_dq,
	output logic o_flash_dq_oe_n,
	input wire logic i_completion_pin
);
	// Flow steps; each step runs at most one engine cycle at a time
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD1 = 3'b001,
		S_CMD2 = 3'b010,
		S_WAIT_PIN = 3'b011,
		S_POLL = 3'b100,
		S_READ = 3'b101,
		S_FINISH = 3'b110
	} state_t;

	state_t state; // Flow sequencer
	flash_host_pkg::op_t op; // Operation in flight
	logic alt_write; // Use the alternate write setup code
	logic use_pin; // Wait on the completion pin before polling
	logic [20:0] addr; // Target address
	logic [15:0] wdata; // Data for a word write
	logic [7:0] op_status; // Last valid operation status byte
	logic multi_ok; // Extended bit 7 as last seen
	logic [15:0] rdata; // Last word read from the flash
	// Progress as software sees it
	logic busy; // Flow in progress
	logic done; // Flow finished since last start
	// Requests to the bus cycle engine
	logic bc_start; // Pulse to the bus cycle engine
	logic bc_rd; // Engine cycle is a read
	logic [7:0] bc_cmd; // Command byte for the engine
	logic bc_data_sel; // Send write data instead of a command
	// Answers from the bus cycle engine
	logic bc_idle; // Engine can take a start
	logic bc_done; // One-cycle pulse at the end of a cycle
	logic [15:0] bc_rdata; // Word captured by the last read cycle
	// Synchronised flash inputs
	logic [15:0] dq_sync; // Data lines after two flops
	logic pin_sync; // Completion pin after two flops
	// Done and idle rise together; a start then would repeat the last cycle
	wire bc_free = bc_idle && !bc_start && !bc_done;

	// Flash inputs come from outside the clock domain
	flash_sync2 #(.W(16)) u_dq_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_async(i_flash_dq),
		.o_sync(dq_sync)
	);
	flash_sync2 #(.W(1)) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_async(i_completion_pin),
		.o_sync(pin_sync)
	);

	// Write data lane: commands sit in the low byte
	wire [15:0] bc_wdata = bc_data_sel ? wdata : {8'h00, bc_cmd};

	// One engine carries every command, data and read cycle
	flash_bus_cycle u_cycle (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_start(bc_start),
		.i_rd(bc_rd),
		.i_addr(addr),
		.i_data(bc_wdata),
		.i_dq_sync(dq_sync),
		.o_idle(bc_idle),
		.o_done(bc_done),
		.o_rdata(bc_rdata),
		.o_ce_n(o_flash_ce_n),
		.o_we_n(o_flash_we_n),
		.o_oe_n(o_flash_oe_n),
		.o_addr(o_flash_addr),
		.o_dq(o_flash_dq),
		.o_dq_oe_n(o_flash_dq_oe_n)
	);

	// APB decode
	// The access phase is never stretched, so a write lands in it
	wire apb_setup = i_psel && !i_penable;
	wire apb_wr = i_psel && i_penable && o_pready && i_pwrite;
	// Register selects on the full byte address; others answer with an error
	wire hit_ctrl = (i_paddr == flash_host_pkg::REG_CTRL);
	wire hit_addr = (i_paddr == flash_host_pkg::REG_ADDR);
	wire hit_wdata = (i_paddr == flash_host_pkg::REG_WDATA);
	wire hit_status = (i_paddr == flash_host_pkg::REG_STATUS);
	wire hit_rdata = (i_paddr == flash_host_pkg::REG_RDATA);
	wire hit_any = hit_ctrl || hit_addr || hit_wdata || hit_status || hit_rdata;
	wire [2:0] wr_op = i_pwdata[flash_host_pkg::CTRL_OP_LSB +: 3];
	// A start is taken only when idle and for a real operation
	wire go = apb_wr && hit_ctrl && !busy && (wr_op != flash_host_pkg::OP_NONE);

	// Decoded error flags, in the order of the full status check
	wire supply_err = op_status[flash_host_pkg::OS_SUPPLY];
	// Abort report only; the lock state itself needs the identifier codes
	wire protect_err = op_status[flash_host_pkg::OS_PROTECT] && !supply_err;
	wire seq_err = op_status[flash_host_pkg::OS_ERASE_ERR]
		&& op_status[flash_host_pkg::OS_WRITE_ERR];
	wire erase_err = op_status[flash_host_pkg::OS_ERASE_ERR] && !seq_err;
	wire write_err = op_status[flash_host_pkg::OS_WRITE_ERR] && !seq_err;

	// Status word for software; bit 0 of the raw byte is masked
	wire [31:0] status_word = {8'h00, op_status & 8'hfe,
		6'h00, multi_ok,
		op_status[flash_host_pkg::OS_WRITE_SUSP],
		op_status[flash_host_pkg::OS_ERASE_SUSP],
		write_err, erase_err, seq_err, protect_err, supply_err, done, busy};
	// Control reads back what started the last operation
	wire [31:0] ctrl_word = {27'h0000000, use_pin, alt_write, op};
	// Read mux; unmapped offsets read zero
	wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
		hit_addr ? {11'h000, addr} :
		hit_wdata ? {16'h0000, wdata} :
		hit_status ? status_word :
		hit_rdata ? {16'h0000, rdata} : 32'h00000000;

	// Zero-wait APB answer: ready and data are set up in the setup cycle
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			// No transfer in flight
			o_pready <= 1'b0;
			o_prdata <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else begin
			// Ready for exactly the one access cycle after each setup
			o_pready <= apb_setup;
			o_prdata <= (apb_setup && !i_pwrite) ? rd_mux : 32'h00000000;
			o_pslverr <= apb_setup && !hit_any;
		end
	end

	// Software-written registers; target and data lock while busy
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr <= flash_host_pkg::ADDR_RESET;
			wdata <= flash_host_pkg::DATA_RESET;
		end else begin
			// Moving the target mid-flow would split a command pair
			if (apb_wr && hit_addr && !busy) begin
				addr <= i_pwdata[20:0];
			end
			// Data for the second cycle of a word write
			if (apb_wr && hit_wdata && !busy) begin
				wdata <= i_pwdata[15:0];
			end
		end
	end

	// First command byte of each operation
	wire [7:0] first_cmd =
		(op == flash_host_pkg::OP_BLOCK_ERASE) ? flash_host_pkg::CMD_BLOCK_ERASE :
		(op == flash_host_pkg::OP_CHIP_ERASE) ? flash_host_pkg::CMD_CHIP_ERASE :
		(op == flash_host_pkg::OP_WRITE) ? (alt_write ? flash_host_pkg::CMD_WRITE_ALT
			: flash_host_pkg::CMD_WRITE) :
		(op == flash_host_pkg::OP_READ_STATUS) ? flash_host_pkg::CMD_READ_STATUS :
		(op == flash_host_pkg::OP_CLEAR_STATUS) ? flash_host_pkg::CMD_CLEAR_STATUS :
		flash_host_pkg::CMD_READ_ARRAY;
	// Operations that need a confirm or data cycle
	wire two_cycle = (op == flash_host_pkg::OP_BLOCK_ERASE)
		|| (op == flash_host_pkg::OP_CHIP_ERASE) || (op == flash_host_pkg::OP_WRITE);
	// Operations that end with one read of the flash
	wire read_after = (op == flash_host_pkg::OP_READ_STATUS)
		|| (op == flash_host_pkg::OP_READ_ARRAY);
	// Ready bit of a status read; lower bits mean nothing until it is set
	wire ready_seen = bc_rdata[flash_host_pkg::OS_READY];

	// Flow sequencer
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			// Idle, with no stored status
			state <= S_IDLE;
			op <= flash_host_pkg::OP_NONE;
			alt_write <= 1'b0;
			use_pin <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			bc_start <= 1'b0;
			bc_rd <= 1'b0;
			bc_cmd <= 8'h00;
			bc_data_sel <= 1'b0;
			op_status <= flash_host_pkg::OS_RESET;
			multi_ok <= 1'b0;
			rdata <= flash_host_pkg::DATA_RESET;
		end else begin
			// Start is a one-cycle pulse; each step but S_POLL raises it at most once
			bc_start <= 1'b0;
			case (state)
				S_IDLE: begin
					// Latch the order and its options
					if (go) begin
						op <= flash_host_pkg::op_t'(wr_op);
						alt_write <= i_pwdata[flash_host_pkg::CTRL_ALT_WRITE];
						use_pin <= i_pwdata[flash_host_pkg::CTRL_USE_PIN];
						busy <= 1'b1;
						done <= 1'b0;
						// A plain word read needs no command first
						state <= (wr_op == flash_host_pkg::OP_READ_WORD) ? S_READ : S_CMD1;
					end
				end
				S_CMD1: begin
					// Issue the setup or single command, then choose the next step
					if (bc_free) begin
						bc_rd <= 1'b0;
						bc_cmd <= first_cmd;
						bc_data_sel <= 1'b0;
						bc_start <= 1'b1;
					end
					// Erase and write go on to their second cycle
					if (bc_done) begin
						state <= two_cycle ? S_CMD2 : (read_after ? S_READ : S_FINISH);
					end
				end
				S_CMD2: begin
					// Confirm or data cycle at the same address
					if (bc_free) begin
						bc_rd <= 1'b0;
						bc_cmd <= flash_host_pkg::CMD_CONFIRM;
						bc_data_sel <= (op == flash_host_pkg::OP_WRITE);
						bc_start <= 1'b1;
					end
					// The device now answers reads with status
					if (bc_done) begin
						state <= use_pin ? S_WAIT_PIN : S_POLL;
					end
				end
				S_WAIT_PIN: begin
					// Pin is pulled high when the machine is ready
					// A pin that never rises hangs the flow here; there is no timeout
					if (pin_sync) begin
						state <= S_POLL;
					end
				end
				S_POLL: begin
					// Device answers reads with status after the confirm
					if (bc_free) begin
						bc_rd <= 1'b1;
						bc_start <= 1'b1;
					end
					// A busy answer is dropped and the next read follows
					if (bc_done && ready_seen) begin
						op_status <= bc_rdata[7:0];
						state <= S_FINISH;
					end
				end
				S_READ: begin
					// One read, of the array or of status
					if (bc_free) begin
						bc_rd <= 1'b1;
						bc_start <= 1'b1;
					end
					if (bc_done) begin
						rdata <= bc_rdata;
						// Status reads update the flags only when ready
						if (op == flash_host_pkg::OP_READ_STATUS && ready_seen) begin
							op_status <= bc_rdata[7:0];
							multi_ok <= bc_rdata[flash_host_pkg::XOS_MULTI_OK];
						end
						state <= S_FINISH;
					end
				end
				S_FINISH: begin
					// Clearing the device status also clears our copy
					if (op == flash_host_pkg::OP_CLEAR_STATUS) begin
						op_status <= flash_host_pkg::OS_RESET;
					end
					// Done stays up until the next start
					busy <= 1'b0;
					done <= 1'b1;
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== rtl/flash_sync2.sv
// Two-flop synchroniser for inputs arriving from the flash pins.
// Assumes the input is a level; no logic may look at the first stage.
`timescale 1ns/10ps
`default_nettype none
module flash_sync2 #(
	parameter int W = 1
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta; // First stage, read only by the second

	// Both stages reset to zero
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta <= '0;
			o_sync <= '0;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end
endmodule
`default_nettype wire
